// [verilog/tcps_consts.vh]
// Constants for the timer clock, power and system control bank
`ifndef TCPS_CONSTS_VH
`define TCPS_CONSTS_VH

// Register addresses
`define TCPS_OFS_TMR        32'h0500000c
`define TCPS_OFS_PMU        32'h50000010
`define TCPS_OFS_SYS        32'h50000012
`define TCPS_OFS_STAT       32'h50000016

// Reset values
`define TCPS_RST_TMR        16'h0000
`define TCPS_RST_PMU        16'h000f
`define TCPS_RST_SYS        16'h0020
`define TCPS_RST_DATA       16'h0000

// Writable bits; others keep reset value
`define TCPS_WMASK_TMR      16'h0fff
`define TCPS_WMASK_PMU      16'hfff7
`define TCPS_WMASK_SYS      16'h7ef8

// Timer clock register fields
`define TCPS_TA_DIV_LO      0
`define TCPS_TA_GATE        2
`define TCPS_TA_SEL         3
`define TCPS_TB_DIV_LO      4
`define TCPS_TB_GATE        6
`define TCPS_TB_SEL         7
`define TCPS_TC_DIV_LO      8
`define TCPS_TC_GATE        10
`define TCPS_TC_SEL         11

// Power unit register fields
`define TCPS_PMU_ECC        15
`define TCPS_PMU_CACHE      14
`define TCPS_PMU_CLKLESS    13
`define TCPS_PMU_RAM_HI     12
`define TCPS_PMU_RAM_LO     8
`define TCPS_PMU_ODIV_HI    7
`define TCPS_PMU_ODIV_LO    6
`define TCPS_PMU_RSTWAKE    5
`define TCPS_PMU_BANDGAP    4
`define TCPS_PMU_LC         2
`define TCPS_PMU_RADIO      1
`define TCPS_PMU_PERIPH     0

// System control register fields
`define TCPS_SYS_SWRST      15
`define TCPS_SYS_REDIR      14
`define TCPS_SYS_OTPCOPY    13
`define TCPS_SYS_QSPI       12
`define TCPS_SYS_DEVPH      11
`define TCPS_SYS_CMUX       10
`define TCPS_SYS_TODIS      9
`define TCPS_SYS_DBG        7
`define TCPS_SYS_OTPCRST    6
`define TCPS_SYS_PADLATCH   5
`define TCPS_SYS_ORD_HI     4
`define TCPS_SYS_ORD_LO     3

// Vector redirect window
`define TCPS_REDIR_LIMIT    32'h000001ff
`define TCPS_REDIR_BASE     32'h07fc0000

// Data RAM slot maps {slot3, slot2, slot1}, 2 bits each, RAM1 = 0
`define TCPS_ORDER_0        6'h24
`define TCPS_ORDER_1        6'h21
`define TCPS_ORDER_2        6'h12
`define TCPS_ORDER_3        6'h06

// Power state machine timeout
`define TCPS_TIMEOUT_US     2000
`define TCPS_CLK_MHZ        50

`endif

// [verilog/tcps_clk_div.v]
// Timer clock tick generator: gate, source select and 1/2/4/8 divider
`default_nettype none

module tcps_clk_div #(
    parameter CNT_W = 3
) (
    input  wire             sys_clk,
    input  wire             sys_rst,
    input  wire [1:0]       div_code,
    input  wire             src_undiv,
    input  wire             gate_en,
    output reg              tick_ff
);

    // Free running prescale counter
    reg  [CNT_W-1:0] cnt_ff;
    // Count bits that must all be one for a tick
    wire [CNT_W-1:0] div_mask;
    wire             div_hit;
    reg              nxt_tick;

    assign div_mask = {div_code == 2'h3, div_code[1], div_code != 2'h0};
    assign div_hit  = (cnt_ff & div_mask) == div_mask;

    // ------------------------------------------------------------
    // Tick selection
    // ------------------------------------------------------------
    always @* begin
        if (!gate_en) begin
            nxt_tick = 1'b0;
        end else if (src_undiv) begin
            nxt_tick = 1'b1;
        end else begin
            nxt_tick = div_hit;
        end
    end

    // Counter and registered tick
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt_ff  <= {CNT_W{1'b0}};
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
            tick_ff <= nxt_tick;
        end
    end

endmodule

`default_nettype wire

// [verilog/tcps_sys_ctrl.v]
// Timer clock, power unit and system control register bank
// How it works
// - Timer divider codes divide by 1,2,4,8
// - Source bit picks undivided clock; enable gates
// - Microcode RAM retention bit keeps it powered
// - Cache retention bit keeps cache powered
// - Clockless sleep stops low-power clock until wakeup
// - One retention bit per system RAM macro
// - Field sets bus clock division during OTP mirror
// - Reset-on-wakeup bit forces hardware reset
// - Bandgap mapping bit routes enable to pad
// - Link-controller sleep bit, resets powered down
// - Access to stopped link controller raises fault
// - Radio and peripheral power-down bits reset high
// - Writing one pulses software reset, reads zero
// - Redirect low 512 bytes to system RAM
// - OTP copy bit starts copy after wakeup
// - QSPI init bit starts flash init after wakeup
// - Development phase suppresses the OTP copy
// - Cache RAM visibility bit selects cache mode
// - Startup waits 2 ms unless timeout disabled
// - Debugger bit frees debug pins when clear
// - Pad latch bit freezes pads when clear
// - Ordering field permutes first three data RAMs
//
// The address-and-strobe port was left to the implementer.
`default_nettype none
`include "tcps_consts.vh"

module tcps_sys_ctrl #(
    parameter TIMEOUT_CYC = `TCPS_TIMEOUT_US * `TCPS_CLK_MHZ,
    parameter TO_W        = 17
) (
    input  wire             sys_clk,
    input  wire             sys_rst,
    input  wire [31:0]      reg_addr,
    input  wire [15:0]      reg_wr_data,
    input  wire             reg_wr,
    input  wire             reg_rd,
    output reg  [15:0]      reg_rd_data_ff,
    input  wire             deep_sleep,
    input  wire             wakeup_event,
    input  wire             blocks_ready,
    input  wire             bandgap_enable,
    input  wire             lc_clock_enable,
    input  wire             lc_reg_access,
    input  wire [31:0]      cpu_addr,
    output wire             timer_a_tick_ff,
    output wire             timer_b_tick_ff,
    output wire             timer_c_tick_ff,
    output reg              microcode_ram_power_ff,
    output reg              cache_block_power_ff,
    output reg  [4:0]       ram_macro_power_ff,
    output reg              low_power_clock_run_ff,
    output reg  [1:0]       otp_copy_clock_div_ff,
    output reg              wake_hw_reset_ff,
    output reg              bandgap_pad_ff,
    output reg              bandgap_pad_select_ff,
    output reg              lc_powerdown_ff,
    output reg              radio_powerdown_ff,
    output reg              peripheral_powerdown_ff,
    output reg              lc_hard_fault_ff,
    output reg              software_reset_trigger_ff,
    output reg  [31:0]      mapped_addr_ff,
    output reg              otp_copy_start_ff,
    output reg              qspi_init_start_ff,
    output reg              cache_ram_visibility_ff,
    output reg              startup_done_ff,
    output reg              debugger_enable_ff,
    output reg              debug_pins_gpio_ff,
    output reg              pad_latch_open_ff,
    output reg  [5:0]       data_ram_slot_map_ff,
    output reg              otp_controller_reset_request_ff
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    localparam PSM_IDLE = 1'b0;        // No startup in progress
    localparam PSM_WAIT = 1'b1;        // Waiting for blocks after wakeup

    reg  [15:0]      tmr_ff;            // Timer clock register
    reg  [15:0]      pmu_ff;            // Power unit register
    reg  [15:0]      sys_ff;            // System control register
    reg              prev_sleep_ff;     // Deep sleep one cycle ago
    reg              psm_state_ff;      // Startup sequencer state
    reg  [TO_W-1:0]  psm_cnt_ff;        // Startup wait counter
    reg              psm_timed_out_ff;  // Last startup ended by timeout
    reg              nxt_lp_run;        // Next low-power clock run level
    reg              nxt_psm_state;     // Next sequencer state
    reg  [TO_W-1:0]  nxt_psm_cnt;       // Next wait count
    reg              nxt_timed_out;     // Next timeout status
    reg              nxt_done;          // Startup completes this cycle
    reg  [15:0]      nxt_rd_data;       // Read mux result
    reg  [5:0]       nxt_slot_map;      // Decoded RAM order

    wire             wr_tmr;            // Write hits timer register
    wire             wr_pmu;            // Write hits power register
    wire             wr_sys;            // Write hits system register
    wire             sleep_entry;       // Deep sleep just began
    wire             wake;              // Deep sleep just ended
    wire             lc_stopped;        // Link controller clock off or sleep bit set
    wire             timeout_hit;       // Startup wait expired
    wire [15:0]      status_word;       // Read-only status view

    assign wr_tmr      = reg_wr && (reg_addr == `TCPS_OFS_TMR);
    assign wr_pmu      = reg_wr && (reg_addr == `TCPS_OFS_PMU);
    assign wr_sys      = reg_wr && (reg_addr == `TCPS_OFS_SYS);
    assign sleep_entry = deep_sleep && !prev_sleep_ff;
    assign wake        = prev_sleep_ff && !deep_sleep;
    assign lc_stopped  = !lc_clock_enable || pmu_ff[`TCPS_PMU_LC];
    assign timeout_hit = !sys_ff[`TCPS_SYS_TODIS] &&
                         (psm_cnt_ff == TIMEOUT_CYC[TO_W-1:0] - 1'b1);
    assign status_word = {12'h000, lc_stopped, psm_timed_out_ff,
                          psm_state_ff, low_power_clock_run_ff};

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Unwritable bits refill from reset values
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            tmr_ff <= `TCPS_RST_TMR;
            pmu_ff <= `TCPS_RST_PMU;
            sys_ff <= `TCPS_RST_SYS;
        end else begin
            if (wr_tmr) begin
                tmr_ff <= (reg_wr_data & `TCPS_WMASK_TMR) |
                          (`TCPS_RST_TMR & ~`TCPS_WMASK_TMR);
            end
            if (wr_pmu) begin
                pmu_ff <= (reg_wr_data & `TCPS_WMASK_PMU) |
                          (`TCPS_RST_PMU & ~`TCPS_WMASK_PMU);
            end
            if (wr_sys) begin
                // Software reset bit is never stored
                sys_ff <= (reg_wr_data & `TCPS_WMASK_SYS) |
                          (`TCPS_RST_SYS & ~`TCPS_WMASK_SYS);
            end
        end
    end

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    // Read data stands one cycle after the strobe
    always @* begin
        nxt_rd_data = `TCPS_RST_DATA;
        if (reg_rd) begin
            case (reg_addr)
                // Timer clock register
                `TCPS_OFS_TMR:  nxt_rd_data = tmr_ff;
                // Power unit register
                `TCPS_OFS_PMU:  nxt_rd_data = pmu_ff;
                // System control; reset bit reads zero
                `TCPS_OFS_SYS:  nxt_rd_data = sys_ff;
                // Block status
                `TCPS_OFS_STAT: nxt_rd_data = status_word;
                // Unmapped addresses read zero
                default:        nxt_rd_data = `TCPS_RST_DATA;
            endcase
        end
    end

    // Read data register
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rd_data_ff <= `TCPS_RST_DATA;
        end else begin
            reg_rd_data_ff <= nxt_rd_data;
        end
    end

    // ------------------------------------------------------------
    // Timer clock ticks
    // ------------------------------------------------------------
    // One tick generator per timer
    tcps_clk_div u_div_a (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .div_code  (tmr_ff[`TCPS_TA_DIV_LO+1:`TCPS_TA_DIV_LO]),
        .src_undiv (tmr_ff[`TCPS_TA_SEL]),
        .gate_en   (tmr_ff[`TCPS_TA_GATE]),
        .tick_ff   (timer_a_tick_ff)
    );

    tcps_clk_div u_div_b (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .div_code  (tmr_ff[`TCPS_TB_DIV_LO+1:`TCPS_TB_DIV_LO]),
        .src_undiv (tmr_ff[`TCPS_TB_SEL]),
        .gate_en   (tmr_ff[`TCPS_TB_GATE]),
        .tick_ff   (timer_b_tick_ff)
    );

    tcps_clk_div u_div_c (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .div_code  (tmr_ff[`TCPS_TC_DIV_LO+1:`TCPS_TC_DIV_LO]),
        .src_undiv (tmr_ff[`TCPS_TC_SEL]),
        .gate_en   (tmr_ff[`TCPS_TC_GATE]),
        .tick_ff   (timer_c_tick_ff)
    );

    // ------------------------------------------------------------
    // Low-power clock in clockless sleep
    // ------------------------------------------------------------
    // Wakeup or leaving sleep wins over the stop
    always @* begin
        nxt_lp_run = low_power_clock_run_ff;
        if (sleep_entry && pmu_ff[`TCPS_PMU_CLKLESS]) begin
            nxt_lp_run = 1'b0;
        end
        if (wakeup_event || !deep_sleep || !pmu_ff[`TCPS_PMU_CLKLESS]) begin
            nxt_lp_run = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Startup sequencer after wakeup
    // ------------------------------------------------------------
    // Ends on ready, or on timeout unless disabled
    always @* begin
        nxt_psm_state = psm_state_ff;
        nxt_psm_cnt   = psm_cnt_ff;
        nxt_timed_out = psm_timed_out_ff;
        nxt_done      = 1'b0;
        case (psm_state_ff)
            // Wait for the end of deep sleep
            PSM_IDLE: begin
                if (wake) begin
                    nxt_psm_state = PSM_WAIT;
                    nxt_psm_cnt   = {TO_W{1'b0}};
                    nxt_timed_out = 1'b0;
                end
            end
            // Wait for the blocks
            PSM_WAIT: begin
                if (blocks_ready) begin
                    nxt_psm_state = PSM_IDLE;
                    nxt_done      = 1'b1;
                end else if (timeout_hit) begin
                    nxt_psm_state = PSM_IDLE;
                    nxt_done      = 1'b1;
                    nxt_timed_out = 1'b1;
                end else if (psm_cnt_ff != {TO_W{1'b1}}) begin
                    nxt_psm_cnt = psm_cnt_ff + {{(TO_W-1){1'b0}}, 1'b1};
                end
            end
            default: begin
                nxt_psm_state = PSM_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Data RAM ordering decode
    // ------------------------------------------------------------
    always @* begin
        case (sys_ff[`TCPS_SYS_ORD_HI:`TCPS_SYS_ORD_LO])
            2'h0:    nxt_slot_map = `TCPS_ORDER_0;
            2'h1:    nxt_slot_map = `TCPS_ORDER_1;
            2'h2:    nxt_slot_map = `TCPS_ORDER_2;
            default: nxt_slot_map = `TCPS_ORDER_3;
        endcase
    end

    // ------------------------------------------------------------
    // Registered control outputs
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            prev_sleep_ff                   <= 1'b0;
            psm_state_ff                    <= PSM_IDLE;
            psm_cnt_ff                      <= {TO_W{1'b0}};
            psm_timed_out_ff                <= 1'b0;
            startup_done_ff                 <= 1'b0;
            microcode_ram_power_ff          <= 1'b1;
            cache_block_power_ff            <= 1'b1;
            ram_macro_power_ff              <= 5'h1f;
            low_power_clock_run_ff          <= 1'b1;
            otp_copy_clock_div_ff           <= 2'h0;
            wake_hw_reset_ff                <= 1'b0;
            bandgap_pad_ff                  <= 1'b0;
            bandgap_pad_select_ff           <= 1'b0;
            lc_powerdown_ff                 <= 1'b1;
            radio_powerdown_ff              <= 1'b1;
            peripheral_powerdown_ff         <= 1'b1;
            lc_hard_fault_ff                <= 1'b0;
            software_reset_trigger_ff       <= 1'b0;
            mapped_addr_ff                  <= 32'h00000000;
            otp_copy_start_ff               <= 1'b0;
            qspi_init_start_ff              <= 1'b0;
            cache_ram_visibility_ff         <= 1'b0;
            debugger_enable_ff              <= 1'b0;
            debug_pins_gpio_ff              <= 1'b1;
            pad_latch_open_ff               <= 1'b1;
            data_ram_slot_map_ff            <= `TCPS_ORDER_0;
            otp_controller_reset_request_ff <= 1'b0;
        end else begin
            prev_sleep_ff          <= deep_sleep;
            psm_state_ff           <= nxt_psm_state;
            psm_cnt_ff             <= nxt_psm_cnt;
            psm_timed_out_ff       <= nxt_timed_out;
            startup_done_ff        <= nxt_done;
            low_power_clock_run_ff <= nxt_lp_run;
            // Retention: powered awake, else per keep bit
            microcode_ram_power_ff <= !deep_sleep || pmu_ff[`TCPS_PMU_ECC];
            cache_block_power_ff   <= !deep_sleep || pmu_ff[`TCPS_PMU_CACHE];
            ram_macro_power_ff     <= {5{!deep_sleep}} |
                                      pmu_ff[`TCPS_PMU_RAM_HI:`TCPS_PMU_RAM_LO];
            otp_copy_clock_div_ff  <= pmu_ff[`TCPS_PMU_ODIV_HI:`TCPS_PMU_ODIV_LO];
            // Reset request pulse on wake
            wake_hw_reset_ff       <= wake && pmu_ff[`TCPS_PMU_RSTWAKE];
            bandgap_pad_select_ff  <= pmu_ff[`TCPS_PMU_BANDGAP];
            bandgap_pad_ff         <= pmu_ff[`TCPS_PMU_BANDGAP] && bandgap_enable;
            lc_powerdown_ff        <= pmu_ff[`TCPS_PMU_LC];
            radio_powerdown_ff     <= pmu_ff[`TCPS_PMU_RADIO];
            peripheral_powerdown_ff <= pmu_ff[`TCPS_PMU_PERIPH];
            // Fault pulse on access while controller clock is off or its sleep bit is set
            lc_hard_fault_ff       <= lc_reg_access && lc_stopped;
            software_reset_trigger_ff <= wr_sys && reg_wr_data[`TCPS_SYS_SWRST];
            // Redirect the low window to RAM
            if (sys_ff[`TCPS_SYS_REDIR] && (cpu_addr <= `TCPS_REDIR_LIMIT)) begin
                mapped_addr_ff <= `TCPS_REDIR_BASE | {23'h000000, cpu_addr[8:0]};
            end else begin
                mapped_addr_ff <= cpu_addr;
            end
            // Wakeup actions and system control outputs
            otp_copy_start_ff      <= wake && sys_ff[`TCPS_SYS_OTPCOPY] &&
                                      !sys_ff[`TCPS_SYS_DEVPH];
            qspi_init_start_ff     <= wake && sys_ff[`TCPS_SYS_QSPI];
            cache_ram_visibility_ff <= sys_ff[`TCPS_SYS_CMUX];
            debugger_enable_ff     <= sys_ff[`TCPS_SYS_DBG];
            debug_pins_gpio_ff     <= !sys_ff[`TCPS_SYS_DBG];
            pad_latch_open_ff      <= sys_ff[`TCPS_SYS_PADLATCH];
            data_ram_slot_map_ff   <= nxt_slot_map;
            otp_controller_reset_request_ff <= sys_ff[`TCPS_SYS_OTPCRST];
        end
    end

endmodule

`default_nettype wire

// [dv/tcps_sys_ctrl_sva.sv]
// Port assertions for the timer, power and system control bank
`default_nettype none
`include "tcps_consts.vh"

module tcps_sys_ctrl_sva (
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic [31:0] reg_addr,
    input wire logic [15:0] reg_wr_data,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rd_data_ff,
    input wire logic        lc_clock_enable,
    input wire logic        lc_reg_access,
    input wire logic [31:0] cpu_addr,
    input wire logic [31:0] mapped_addr_ff,
    input wire logic        lc_hard_fault_ff,
    input wire logic        software_reset_trigger_ff,
    input wire logic        bandgap_pad_ff,
    input wire logic        bandgap_pad_select_ff,
    input wire logic        debugger_enable_ff,
    input wire logic        debug_pins_gpio_ff,
    input wire logic        peripheral_powerdown_ff,
    input wire logic        pad_latch_open_ff
);
    // ---------------------------------------------
    // Clocking and write sequences
    // ---------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence pmu_wr_s; reg_wr && reg_addr == `TCPS_OFS_PMU; endsequence
    sequence sys_wr_s; reg_wr && reg_addr == `TCPS_OFS_SYS; endsequence

    rd_idle_a: assert property (!reg_rd |=> reg_rd_data_ff == 16'h0000)
        else $error("stray read data");
    rsvd_bit_a: assert property (reg_rd && reg_addr == `TCPS_OFS_PMU |=> reg_rd_data_ff[3])
        else $error("reserved bit lost");
    swrst_pulse_a: assert property (software_reset_trigger_ff == $past(reg_wr && reg_wr_data[15] && reg_addr == `TCPS_OFS_SYS))
        else $error("reset pulse wrong");
    swrst_read_a: assert property (reg_rd && reg_addr == `TCPS_OFS_SYS |=> !reg_rd_data_ff[15])
        else $error("reset bit reads back");
    lc_fault_a: assert property (lc_reg_access && !lc_clock_enable |=> lc_hard_fault_ff)
        else $error("fault missing");
    redir_out_a: assert property (cpu_addr > `TCPS_REDIR_LIMIT |=> mapped_addr_ff == $past(cpu_addr))
        else $error("address altered");
    gpio_pins_a: assert property (debug_pins_gpio_ff != debugger_enable_ff)
        else $error("debug pins wrong");
    bandgap_off_a: assert property (!bandgap_pad_select_ff |-> !bandgap_pad_ff)
        else $error("bandgap on pad");
    periph_pd_a: assert property (pmu_wr_s |-> ##2 peripheral_powerdown_ff == $past(reg_wr_data[0], 2))
        else $error("power-down stale");
    pad_latch_a: assert property (sys_wr_s |-> ##2 pad_latch_open_ff == $past(reg_wr_data[5], 2))
        else $error("pad latch stale");
endmodule

bind tcps_sys_ctrl tcps_sys_ctrl_sva i_tcps_sys_ctrl_sva (.*);
`default_nettype wire

// [dv/test_tcps_sys_ctrl.sv]
// Self-checking bench for the timer, power and system control bank
`default_nettype none
`include "tcps_consts.vh"

module test_tcps_sys_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------
    // Stimulus and observed signals
    // ---------------------------------------------
    logic        sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [31:0] reg_addr = 32'h0, cpu_addr = 32'h0, mapped_addr_ff;
    logic [15:0] reg_wr_data = 16'h0, reg_rd_data_ff;
    logic        deep_sleep = 1'b0, wakeup_event = 1'b0, blocks_ready = 1'b0;
    logic        bandgap_enable = 1'b1, lc_clock_enable = 1'b1, lc_reg_access = 1'b0;
    logic        timer_a_tick_ff, timer_b_tick_ff, timer_c_tick_ff, microcode_ram_power_ff;
    logic        cache_block_power_ff, low_power_clock_run_ff, wake_hw_reset_ff, bandgap_pad_ff;
    logic        bandgap_pad_select_ff, lc_powerdown_ff, radio_powerdown_ff, peripheral_powerdown_ff;
    logic        lc_hard_fault_ff, software_reset_trigger_ff, otp_copy_start_ff, qspi_init_start_ff;
    logic        cache_ram_visibility_ff, startup_done_ff, debugger_enable_ff, debug_pins_gpio_ff;
    logic        pad_latch_open_ff, otp_controller_reset_request_ff;
    logic [4:0]  ram_macro_power_ff;
    logic [1:0]  otp_copy_clock_div_ff;
    logic [5:0]  data_ram_slot_map_ff;
    logic [5:0]  maps [4] = '{6'h24, 6'h21, 6'h12, 6'h06};  // Slot map per code
    int          mismatches = 0, total_checks = 0;

    // Short startup timeout
    tcps_sys_ctrl #(.TIMEOUT_CYC(20)) i_tcps_sys_ctrl (.*);

    initial forever #10 sys_clk = ~sys_clk;

    // ---------------------------------------------
    // Bus cycles and checks
    // ---------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rd_data_ff, e);
    endtask

    // ---------------------------------------------
    // Scenarios
    // ---------------------------------------------
    task automatic t_reset;
        chk({lc_powerdown_ff, radio_powerdown_ff, peripheral_powerdown_ff}, 3'h7);
        chk({pad_latch_open_ff, data_ram_slot_map_ff}, 7'h64);
        rd(`TCPS_OFS_TMR, 16'h0000);
        rd(`TCPS_OFS_PMU, 16'h000f);
        rd(`TCPS_OFS_SYS, 16'h0020);
        rd(32'h50000014, 16'h0000);
        wr(`TCPS_OFS_TMR, 16'hffff);
        rd(`TCPS_OFS_TMR, 16'h0fff);
        wr(`TCPS_OFS_PMU, 16'h0000);
        rd(`TCPS_OFS_PMU, 16'h0008);
        wr(`TCPS_OFS_SYS, 16'h7fff);
        rd(`TCPS_OFS_SYS, 16'h7ef8);
        chk({otp_controller_reset_request_ff, radio_powerdown_ff}, 2'h2);
    endtask
    // Timer a /4, b undivided, c /8
    task automatic t_timers;
        int na = 0, nb = 0, nc = 0;
        wr(`TCPS_OFS_TMR, 16'h07c6);
        cyc(2);
        repeat (32) begin
            cyc(1);
            na += timer_a_tick_ff;
            nb += timer_b_tick_ff;
            nc += timer_c_tick_ff;
        end
        chk({na[7:0], nb[7:0], nc[7:0]}, 24'h082004);
    endtask
    task automatic t_power;
        wr(`TCPS_OFS_PMU, 16'haab0);
        cyc(1);
        chk({bandgap_pad_ff, otp_copy_clock_div_ff, lc_powerdown_ff, peripheral_powerdown_ff}, 5'h18);
        @(posedge sys_clk);
        deep_sleep <= 1'b1;
        cyc(3);
        chk({microcode_ram_power_ff, cache_block_power_ff, ram_macro_power_ff}, 7'h4a);
        chk(low_power_clock_run_ff, 1'b0);
        @(posedge sys_clk);
        wakeup_event <= 1'b1;
        @(posedge sys_clk);
        wakeup_event <= 1'b0;
        cyc(1);
        chk(low_power_clock_run_ff, 1'b1);
    endtask
    // Wake pulses and startup wait end
    task automatic t_wake(input logic [15:0] sv, input int eo, eq, er, lo, hi);
        int no = 0, nq = 0, nr = 0, td = 0;
        wr(`TCPS_OFS_SYS, sv);
        @(posedge sys_clk);
        deep_sleep <= 1'b1;
        @(posedge sys_clk);
        deep_sleep <= 1'b0;
        for (int i = 1; i <= 60; i++) begin
            cyc(1);
            no += otp_copy_start_ff;
            nq += qspi_init_start_ff;
            nr += wake_hw_reset_ff;
            if (startup_done_ff === 1'b1 && td == 0) td = i;
        end
        chk({no[3:0], nq[3:0], nr[3:0]}, {eo[3:0], eq[3:0], er[3:0]});
        chk(td >= lo && td <= hi, 1'b1);
    endtask
    task automatic t_fault(input logic en, input logic exp);
        @(posedge sys_clk);
        lc_clock_enable <= en;
        lc_reg_access <= 1'b1;
        @(posedge sys_clk);
        lc_reg_access <= 1'b0;
        #1 chk(lc_hard_fault_ff, exp);
    endtask
    task automatic t_sys;
        wr(`TCPS_OFS_SYS, 16'h8000);
        #1 chk(software_reset_trigger_ff, 1'b1);
        cyc(1);
        chk(software_reset_trigger_ff, 1'b0);
        for (int k = 0; k < 4; k++) begin
            wr(`TCPS_OFS_SYS, 16'h4480 | 16'(k << 3));
            cyc(1);
            chk(data_ram_slot_map_ff, maps[k]);
        end
        chk({cache_ram_visibility_ff, debugger_enable_ff, debug_pins_gpio_ff}, 3'h6);
        @(posedge sys_clk);
        cpu_addr <= 32'h000001fc;
        cyc(1);
        chk(mapped_addr_ff, 32'h07fc01fc);
        @(posedge sys_clk);
        cpu_addr <= 32'h00000200;
        cyc(1);
        chk(mapped_addr_ff, 32'h00000200);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        cyc(1);
        t_reset;
        t_timers;
        t_power;
        t_wake(16'h3020, 1, 1, 1, 18, 24);
        t_wake(16'h2a20, 0, 0, 1, 0, 0);
        @(posedge sys_clk);
        blocks_ready <= 1'b1;
        @(posedge sys_clk);
        blocks_ready <= 1'b0;
        #1 chk(startup_done_ff, 1'b1);
        t_sys;
        t_fault(1'b1, 1'b0);
        t_fault(1'b0, 1'b1);
        wr(`TCPS_OFS_PMU, 16'h0004);
        t_fault(1'b1, 1'b1);
        print_verdict;
    end

    // Watchdog
    initial begin
        #400000;
        mismatches++;
        print_verdict;
    end
endmodule
`default_nettype wire
